/* sbtm_timer.sv */
// sbtm_timer: 16-bit timer, two captures, two compares, one-pulse, pwm.
// assumes capture and clock pins already synchronous to hclk,
// except the external count clock, which is resynchronised here.
`timescale 1ns/100ps
module sbtm_timer import sbtm_pkg::*; #(
  parameter bit HAS_EXT_PIN = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic external_count_clock,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  output logic compare_output_one,
  output logic compare_output_one_oe,
  output logic compare_output_two,
  output logic compare_output_two_oe,
  output logic timer_irq,
  output logic wait_wakeup
);

  // edge detector shared by captures and external clock
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic rising);
    edge_hit = rising ? (cur & ~prev) : (prev & ~cur);
  endfunction

  logic [7:0] ctrl_a_q; // timer_control_a
  logic [7:0] ctrl_b_q; // timer_control_b
  logic dis_q; // timer_disable_bit
  logic cap1_flag_q, cmp1_flag_q, ovf_flag_q, cap2_flag_q, cmp2_flag_q;
  logic [4:0] armed_q; // flags seen by a status read
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] presc_q;
  logic [15:0] cmp1_q, cmp2_q; // software values
  logic [15:0] cmp1_act_q, cmp2_act_q; // values in use
  logic cmp1_inh_q, cmp2_inh_q; // high written, low pending
  logic [15:0] cap1_q, cap2_q;
  logic cap1_prev_q, cap2_prev_q;
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic out1_q, out2_q, oe1_q, oe2_q;
  logic irq_q, wake_q;
  logic [31:0] rdata_q;

  // bus phase bookkeeping
  logic take;
  logic dp_wr_q;
  logic [3:0] dp_idx_q;
  logic [3:0] ap_idx;
  logic ap_rd;
  logic wr_ev;
  logic [7:0] wdat;

  // decoded mode bits, events and access strobes
  logic pwm_on, pulse_on, tick, ext_edge, cnt_write;
  logic cap1_ev, cap2_ev, m1, m2, ovf_ev;
  logic acc_cap1_lo, acc_cmp1_lo, acc_cnt_lo, acc_cap2_lo, acc_cmp2_lo;
  logic irq_raw;
  sbtm_clk_t clk_sel;

  assign take = hsel & htrans[1] & hready;
  assign ap_idx = haddr[5:2];
  assign ap_rd = take & ~hwrite & (haddr[31:6] == 26'h0);
  assign wdat = hwdata[7:0];
  assign wr_ev = dp_wr_q;

  // low-byte accesses by read (address phase) or write (data phase)
  function automatic logic hit(input logic [3:0] idx);
    hit = (ap_rd & (ap_idx == idx)) | (wr_ev & (dp_idx_q == idx));
  endfunction

  // a process, not assigns: hit reads bus state that is not an argument
  always_comb begin
    acc_cap1_lo = hit(IDX_CAP1_LO);
    acc_cmp1_lo = hit(IDX_CMP1_LO);
    acc_cnt_lo = hit(IDX_CNT_LO); // alternate low excluded
    acc_cap2_lo = hit(IDX_CAP2_LO);
    acc_cmp2_lo = hit(IDX_CMP2_LO);
  end
  // counter reset by writing either low counter byte
  assign cnt_write = wr_ev & ((dp_idx_q == IDX_CNT_LO) |
                              (dp_idx_q == IDX_ACNT_LO));

  assign pwm_on = ctrl_b_q[B_PWM]; // pwm wins over one-pulse
  assign pulse_on = ctrl_b_q[B_ONE_PULSE] & ~ctrl_b_q[B_PWM];
  assign clk_sel = sbtm_clk_t'({ctrl_b_q[B_CLK_HI], ctrl_b_q[B_CLK_LO]});
  // only the second and third flop outputs feed the edge detector
  assign ext_edge = edge_hit(ext_prev_q, ext_s2_q,
                             ctrl_b_q[B_EXT_EDGE]);

  // tick select; external mode without a pin never ticks
  always_comb begin
    case (clk_sel)
      SBTM_CLK_DIV4: tick = (presc_q[1:0] == DIV4_END[1:0]);
      SBTM_CLK_DIV2: tick = (presc_q[0] == DIV2_END[0]);
      SBTM_CLK_DIV8: tick = (presc_q == DIV8_END);
      SBTM_CLK_EXT: tick = HAS_EXT_PIN & ext_edge;
      default: tick = 1'b0;
    endcase
    if (dis_q | halt_mode) begin
      tick = 1'b0; // frozen
    end
  end

  // capture edges; capture one is owned by the pulse logic in pwm
  assign cap1_ev = ~pwm_on & edge_hit(cap1_prev_q, capture_input_one,
                   ctrl_a_q[A_EDGE1]);
  assign cap2_ev = edge_hit(cap2_prev_q, capture_input_two,
                   ctrl_b_q[B_EDGE2]);

  // next count and match detection on the value being entered
  always_comb begin
    cnt_d = cnt_q;
    if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    m1 = tick & ~cmp1_inh_q & (cnt_d == cmp1_act_q);
    m2 = tick & ~cmp2_inh_q & (cnt_d == cmp2_act_q);
    ovf_ev = tick & (cnt_q == CNT_MAX);
    if (cnt_write | (pulse_on & cap1_ev)) begin
      cnt_d = CNT_RST; // pulse start
    end else if (pwm_on & m2) begin
      cnt_d = CNT_RST; // period end
    end
  end

  // bus address phase capture, answer always immediate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_idx_q <= 4'h0;
    end else begin
      dp_wr_q <= take & hwrite & (haddr[31:6] == 26'h0);
      dp_idx_q <= ap_idx;
    end
  end

  // read data mux, registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      rdata_q <= 32'h0000_0000; // unmapped reads as zero
      if (ap_rd) begin
        case (ap_idx)
          IDX_CTRL_B: rdata_q[7:0] <= ctrl_b_q;
          IDX_CTRL_A: rdata_q[7:0] <= ctrl_a_q;
          IDX_FLAGS: rdata_q[7:0] <= {cap1_flag_q, cmp1_flag_q,
                       ovf_flag_q, cap2_flag_q, cmp2_flag_q, dis_q, 2'b00};
          IDX_CAP1_HI: rdata_q[7:0] <= cap1_q[15:8];
          IDX_CAP1_LO: rdata_q[7:0] <= cap1_q[7:0];
          IDX_CMP1_HI: rdata_q[7:0] <= cmp1_q[15:8];
          IDX_CMP1_LO: rdata_q[7:0] <= cmp1_q[7:0];
          IDX_CNT_HI, IDX_ACNT_HI: rdata_q[7:0] <= cnt_q[15:8];
          IDX_CNT_LO, IDX_ACNT_LO: rdata_q[7:0] <= cnt_q[7:0];
          IDX_CAP2_HI: rdata_q[7:0] <= cap2_q[15:8];
          IDX_CAP2_LO: rdata_q[7:0] <= cap2_q[7:0];
          IDX_CMP2_HI: rdata_q[7:0] <= cmp2_q[15:8];
          IDX_CMP2_LO: rdata_q[7:0] <= cmp2_q[7:0];
          default: rdata_q[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // control registers and disable bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_q <= CTRL_RST;
      ctrl_b_q <= CTRL_RST;
      dis_q <= 1'b0;
    end else if (wr_ev) begin
      if (dp_idx_q == IDX_CTRL_A) begin
        ctrl_a_q <= wdat;
      end
      if (dp_idx_q == IDX_CTRL_B) begin
        ctrl_b_q <= wdat;
      end
      if (dp_idx_q == IDX_FLAGS) begin
        dis_q <= wdat[F_DIS]; // only writable bit there
      end
    end
  end

  // compare values with high-byte inhibit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp1_q <= CMP_RST;
      cmp2_q <= CMP_RST;
      cmp1_inh_q <= 1'b0;
      cmp2_inh_q <= 1'b0;
    end else if (wr_ev) begin
      case (dp_idx_q)
        IDX_CMP1_HI: begin
          cmp1_q[15:8] <= wdat;
          cmp1_inh_q <= 1'b1;
        end
        IDX_CMP1_LO: begin
          cmp1_q[7:0] <= wdat;
          cmp1_inh_q <= 1'b0;
        end
        IDX_CMP2_HI: begin
          cmp2_q[15:8] <= wdat;
          cmp2_inh_q <= 1'b1;
        end
        IDX_CMP2_LO: begin
          cmp2_q[7:0] <= wdat;
          cmp2_inh_q <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // in pwm new values wait for the period end to avoid output spikes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp1_act_q <= CMP_RST;
      cmp2_act_q <= CMP_RST;
    end else if (~pwm_on | m2) begin
      cmp1_act_q <= cmp1_q;
      cmp2_act_q <= cmp2_q;
    end
  end

  // prescaler, counter and external clock resync
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= 3'h0;
      cnt_q <= CNT_RST;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_clock;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      if (~dis_q & ~halt_mode) begin
        presc_q <= presc_q + 3'h1; // frozen when disabled
      end
      cnt_q <= cnt_d;
    end
  end

  // capture inputs and their value registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap1_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end else begin
      cap1_prev_q <= capture_input_one;
      cap2_prev_q <= capture_input_two;
      if (cap1_ev) begin
        cap1_q <= cnt_q;
      end
      if (cap2_ev) begin
        cap2_q <= cnt_q;
      end
    end
  end

  // status read arms each flag that is set at that moment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 5'h00;
    end else if (ap_rd & (ap_idx == IDX_FLAGS)) begin
      armed_q <= {cap1_flag_q, cmp1_flag_q, ovf_flag_q, cap2_flag_q,
                  cmp2_flag_q};
    end
  end

  // event flags; a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap1_flag_q <= 1'b0;
      cmp1_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      cap2_flag_q <= 1'b0;
      cmp2_flag_q <= 1'b0;
    end else begin
      if (cap1_ev | (pwm_on & m2)) begin
        cap1_flag_q <= 1'b1;
      end else if (armed_q[4] & acc_cap1_lo) begin
        cap1_flag_q <= 1'b0;
      end
      // no compare one flag in one-pulse or pwm
      if (m1 & ~pwm_on & ~pulse_on) begin
        cmp1_flag_q <= 1'b1;
      end else if (armed_q[3] & acc_cmp1_lo) begin
        cmp1_flag_q <= 1'b0;
      end
      if (ovf_ev) begin
        ovf_flag_q <= 1'b1;
      end else if (armed_q[2] & acc_cnt_lo) begin
        ovf_flag_q <= 1'b0;
      end
      if (cap2_ev) begin
        cap2_flag_q <= 1'b1;
      end else if (armed_q[1] & acc_cap2_lo) begin
        cap2_flag_q <= 1'b0;
      end
      if (m2 & ~pwm_on) begin
        cmp2_flag_q <= 1'b1;
      end else if (armed_q[0] & acc_cmp2_lo) begin
        cmp2_flag_q <= 1'b0;
      end
    end
  end

  // compare output levels; compares run whatever the pin enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
    end else begin
      if (pwm_on | pulse_on) begin
        if ((pwm_on & m2) | (pulse_on & cap1_ev)) begin
          out1_q <= ctrl_a_q[A_LVL2];
        end else if (m1) begin
          out1_q <= ctrl_a_q[A_LVL1];
        end
      end else begin
        if (m1) begin
          out1_q <= ctrl_a_q[A_LVL1];
        end
        if (m2) begin
          out2_q <= ctrl_a_q[A_LVL2];
        end
      end
      // forcing on a control write with the force bit set
      if (wr_ev & (dp_idx_q == IDX_CTRL_A)) begin
        if (wdat[A_FORCE1]) begin
          out1_q <= wdat[A_LVL1];
        end
        if (wdat[A_FORCE2]) begin
          out2_q <= wdat[A_LVL2];
        end
      end
    end
  end

  // pin routing; enables only select the timer onto the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe1_q <= 1'b0;
      oe2_q <= 1'b0;
    end else begin
      oe1_q <= ctrl_b_q[B_PIN1_EN] & ~dis_q;
      oe2_q <= ctrl_b_q[B_PIN2_EN] & ~dis_q & ~(pwm_on | pulse_on);
    end
  end

  // one shared request, gated by the cpu mask
  assign irq_raw =
    (ctrl_a_q[A_CAP_IE] & (cap1_flag_q | cap2_flag_q)) |
    (ctrl_a_q[A_CMP_IE] & (cmp1_flag_q | cmp2_flag_q)) |
    (ctrl_a_q[A_OVF_IE] & ovf_flag_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= irq_raw & ~cpu_irq_mask;
      // halt never woken by the timer
      wake_q <= irq_raw & ~cpu_irq_mask & wait_mode & ~halt_mode;
    end
  end

  // hsize is fixed at word; unused bits of it carry no meaning here
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign compare_output_one = out1_q;
  assign compare_output_one_oe = oe1_q;
  assign compare_output_two = out2_q;
  assign compare_output_two_oe = oe2_q;
  assign timer_irq = irq_q;
  assign wait_wakeup = wake_q;

endmodule // sbtm_timer

/* sbtm_pkg.sv */
// sbtm_pkg: constants for the 16-bit capture/compare timer.
// assumes one AHB-Lite slave per instance, byte registers in word slots.
package sbtm_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL_B = 4'h1;
  localparam logic [3:0] IDX_CTRL_A = 4'h2;
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_CAP1_HI = 4'h4;
  localparam logic [3:0] IDX_CAP1_LO = 4'h5;
  localparam logic [3:0] IDX_CMP1_HI = 4'h6;
  localparam logic [3:0] IDX_CMP1_LO = 4'h7;
  localparam logic [3:0] IDX_CNT_HI = 4'h8;
  localparam logic [3:0] IDX_CNT_LO = 4'h9;
  localparam logic [3:0] IDX_ACNT_HI = 4'hA;
  localparam logic [3:0] IDX_ACNT_LO = 4'hB;
  localparam logic [3:0] IDX_CAP2_HI = 4'hC;
  localparam logic [3:0] IDX_CAP2_LO = 4'hD;
  localparam logic [3:0] IDX_CMP2_HI = 4'hE;
  localparam logic [3:0] IDX_CMP2_LO = 4'hF;
  // control a bit positions
  localparam int A_CAP_IE = 7;
  localparam int A_CMP_IE = 6;
  localparam int A_OVF_IE = 5;
  localparam int A_FORCE2 = 4;
  localparam int A_FORCE1 = 3;
  localparam int A_LVL2 = 2;
  localparam int A_EDGE1 = 1;
  localparam int A_LVL1 = 0;
  // control b bit positions
  localparam int B_PIN1_EN = 7;
  localparam int B_PIN2_EN = 6;
  localparam int B_ONE_PULSE = 5;
  localparam int B_PWM = 4;
  localparam int B_CLK_HI = 3;
  localparam int B_CLK_LO = 2;
  localparam int B_EDGE2 = 1;
  localparam int B_EXT_EDGE = 0;
  // flags register bit positions
  localparam int F_CAP1 = 7;
  localparam int F_CMP1 = 6;
  localparam int F_OVF = 5;
  localparam int F_CAP2 = 4;
  localparam int F_CMP2 = 3;
  localparam int F_DIS = 2;
  // reset and reload values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'hFFFC;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CMP_RST = 16'h8000;
  // prescaler terminal counts for /4, /2, /8
  localparam logic [2:0] DIV4_END = 3'h3;
  localparam logic [2:0] DIV2_END = 3'h1;
  localparam logic [2:0] DIV8_END = 3'h7;
  // clock select codes
  typedef enum logic [1:0] {
    SBTM_CLK_DIV4 = 2'b00,
    SBTM_CLK_DIV2 = 2'b01,
    SBTM_CLK_DIV8 = 2'b10,
    SBTM_CLK_EXT = 2'b11
  } sbtm_clk_t;
endpackage

/* sbtm_timer_properties.sv */
// sbtm_timer_properties: port-level checks for the capture/compare timer.
// assumes a zero-wait AHB-Lite slave; shadows two control bytes itself.
`timescale 1ns/100ps
module sbtm_timer_properties import sbtm_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cpu_irq_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic compare_output_one,
  input wire logic compare_output_one_oe,
  input wire logic compare_output_two,
  input wire logic compare_output_two_oe,
  input wire logic timer_irq,
  input wire logic wait_wakeup
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_q; // write data phase pending
  logic [3:0] idx_q; // register index from the address phase
  logic [7:0] ctla_q; // shadow of control a
  logic [7:0] ctlb_q; // shadow of control b
  logic dis_q; // shadow of the disable bit
  logic wr_a; // control a written this cycle
  assign wr_a = wr_q && idx_q == IDX_CTRL_A;
  // address phase capture; out-of-range addresses never write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      idx_q <= 4'h0;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite && haddr[31:6] == 26'h0;
      idx_q <= haddr[5:2];
    end
  end
  // shadows land with the data phase, as the slave's registers do
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctla_q <= CTRL_RST;
      ctlb_q <= CTRL_RST;
      dis_q <= 1'b0;
    end else if (wr_q) begin
      if (idx_q == IDX_CTRL_A) ctla_q <= hwdata[7:0];
      if (idx_q == IDX_CTRL_B) ctlb_q <= hwdata[7:0];
      if (idx_q == IDX_FLAGS) dis_q <= hwdata[F_DIS];
    end
  end
  // forced writes with the pin routed and no special mode
  sequence s_force1;
    wr_a && hwdata[A_FORCE1] && ctlb_q[B_PIN1_EN] && !dis_q
      && !ctlb_q[B_PWM] && !ctlb_q[B_ONE_PULSE];
  endsequence
  sequence s_force2;
    wr_a && hwdata[A_FORCE2] && ctlb_q[B_PIN2_EN] && !dis_q
      && !ctlb_q[B_PWM] && !ctlb_q[B_ONE_PULSE];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_holds: assert property (
    !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_irq_masked: assert property (cpu_irq_mask |=> !timer_irq)
    else $error("request raised while masked");
  a_halt_no_wake: assert property (halt_mode |=> !wait_wakeup)
    else $error("wakeup raised in halt");
  a_wake_needs_wait: assert property (!wait_mode |=> !wait_wakeup)
    else $error("wakeup raised outside wait");
  a_pin_one_route: assert property (
    compare_output_one_oe == $past(ctlb_q[B_PIN1_EN] && !dis_q))
    else $error("pin one enable does not follow control");
  a_pin_two_route: assert property (
    compare_output_two_oe == $past(ctlb_q[B_PIN2_EN] && !dis_q
      && !ctlb_q[B_PWM] && !ctlb_q[B_ONE_PULSE]))
    else $error("pin two enable does not follow control");
  a_force_one_level: assert property (
    s_force1 |=> ##[0:1] compare_output_one == ctla_q[A_LVL1])
    else $error("forced level one not on pin one");
  a_force_two_level: assert property (
    s_force2 |=> ##[0:1] compare_output_two == ctla_q[A_LVL2])
    else $error("forced level two not on pin two");
endmodule // sbtm_timer_properties

bind sbtm_timer sbtm_timer_properties u_props (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .cpu_irq_mask, .wait_mode, .halt_mode, .compare_output_one,
  .compare_output_one_oe, .compare_output_two, .compare_output_two_oe,
  .timer_irq, .wait_wakeup);

/* sbtm_pins_model.sv */
// sbtm_pins_model: capture and external clock pins facing the timer.
// assumes the bench calls flip right after a rising hclk edge.
`timescale 1ns/100ps
module sbtm_pins_model (
  input wire logic hclk,
  output logic capture_input_one,
  output logic capture_input_two,
  output logic external_count_clock
);
  // idle levels; input two starts high so its first move is a fall
  initial begin
    capture_input_one = 1'b0;
    capture_input_two = 1'b1;
    external_count_clock = 1'b0;
  end
  // toggle chosen pins, then let the resync stages settle
  task automatic flip(input logic c1, input logic c2, input logic ex);
    @(posedge hclk);
    capture_input_one <= capture_input_one ^ c1;
    capture_input_two <= capture_input_two ^ c2;
    external_count_clock <= external_count_clock ^ ex;
    repeat (8) @(posedge hclk);
  endtask
endmodule // sbtm_pins_model

/* tb_sbtm_timer.sv */
// tb_sbtm_timer: directed bench for the capture/compare timer.
// assumes the checker binds itself; pins come from sbtm_pins_model.
`timescale 1ns/100ps
module tb_sbtm_timer import sbtm_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic capture_input_one, capture_input_two, external_count_clock;
  logic cpu_irq_mask, wait_mode, halt_mode, timer_irq, wait_wakeup;
  logic compare_output_one, compare_output_one_oe;
  logic compare_output_two, compare_output_two_oe;
  logic [7:0] a, b; // counter samples
  int miscompares, check_count;
  int div[3] = '{4, 2, 8}; // prescale per clock select code
  assign hready = hreadyout; // single slave
  assign hsize = 3'h2; // whole words only
  sbtm_timer dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .capture_input_one,
    .capture_input_two, .external_count_clock, .cpu_irq_mask, .wait_mode,
    .halt_mode, .compare_output_one, .compare_output_one_oe,
    .compare_output_two, .compare_output_two_oe, .timer_irq, .wait_wakeup);
  sbtm_pins_model u_pins (.hclk, .capture_input_one, .capture_input_two,
    .external_count_clock);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one single transfer; waits bounded on hready in both phases
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {26'h0, idx, 2'h0};
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) n = 100; // address phase never taken
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      report_and_stop();
    end
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, i, d, x);
  endtask
  task automatic chk8(input logic [3:0] i, input logic [7:0] m,
                      input logic [7:0] e);
    logic [7:0] v;
    bus(1'b0, i, 8'h00, v);
    cmp8(v & m, e);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cpu_irq_mask = 1'b0;
    wait_mode = 1'b0;
    halt_mode = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, plus the unmapped slot at index zero
    chk8(IDX_CTRL_A, 8'hFF, CTRL_RST);
    chk8(IDX_CTRL_B, 8'hFF, CTRL_RST);
    chk8(IDX_CMP1_HI, 8'hFF, CMP_RST[15:8]);
    chk8(IDX_CMP2_LO, 8'hFF, 8'h00);
    chk8(4'h0, 8'hFF, 8'h00);
    chk8(IDX_FLAGS, 8'h04, 8'h00);
    // count rate per prescale; spacing 64 hides prescaler phase
    for (int c = 0; c < 3; c++) begin
      wr(IDX_CTRL_B, {4'h0, c[1:0], 2'h0});
      bus(1'b0, IDX_CNT_LO, 8'h00, a);
      repeat (61) @(posedge hclk);
      bus(1'b0, IDX_CNT_LO, 8'h00, b);
      cmp8(b - a, 8'(64 / div[c]));
    end
    // disabled: counter frozen, reload still works
    wr(IDX_FLAGS, 8'h04);
    bus(1'b0, IDX_CNT_LO, 8'h00, a);
    repeat (20) @(posedge hclk);
    bus(1'b0, IDX_CNT_LO, 8'h00, b);
    cmp8(b - a, 8'h00);
    wr(IDX_CNT_LO, 8'h00);
    chk8(IDX_CNT_LO, 8'hFF, CNT_RST[7:0]);
    // external clock, rising then falling edges counted
    wr(IDX_CTRL_B, 8'h0D);
    wr(IDX_FLAGS, 8'h00);
    bus(1'b0, IDX_CNT_LO, 8'h00, a);
    repeat (3) u_pins.flip(1'b0, 1'b0, 1'b1);
    bus(1'b0, IDX_CNT_LO, 8'h00, b);
    cmp8(b - a, 8'h02);
    wr(IDX_CTRL_B, 8'h0C);
    bus(1'b0, IDX_CNT_LO, 8'h00, a);
    u_pins.flip(1'b0, 1'b0, 1'b1);
    bus(1'b0, IDX_CNT_LO, 8'h00, b);
    cmp8(b - a, 8'h01);
    // captures on a frozen count: wrong edges first, then right ones
    wr(IDX_CTRL_A, 8'h80);
    wr(IDX_CTRL_B, 8'h0E);
    bus(1'b0, IDX_CNT_LO, 8'h00, a);
    u_pins.flip(1'b1, 1'b1, 1'b0);
    chk8(IDX_FLAGS, 8'h90, 8'h00);
    u_pins.flip(1'b1, 1'b1, 1'b0);
    chk8(IDX_FLAGS, 8'h90, 8'h90);
    cmp8({7'h0, timer_irq}, 8'h01);
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp8({7'h0, timer_irq}, 8'h00);
    cpu_irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp8({7'h0, wait_wakeup}, 8'h01);
    halt_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp8({7'h0, wait_wakeup}, 8'h00);
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    chk8(IDX_CAP1_LO, 8'hFF, a);
    chk8(IDX_FLAGS, 8'h90, 8'h10);
    chk8(IDX_CAP2_LO, 8'hFF, a);
    chk8(IDX_FLAGS, 8'h90, 8'h00);
    cmp8({7'h0, timer_irq}, 8'h00);
    // compares stepped by external rising edges from FFFC
    wr(IDX_CTRL_A, 8'h41);
    wr(IDX_CTRL_B, 8'hCD);
    wr(IDX_CNT_LO, 8'h00);
    wr(IDX_CMP1_HI, 8'hFF);
    wr(IDX_CMP1_LO, 8'hFE);
    wr(IDX_CMP2_LO, 8'hFF);
    wr(IDX_CMP2_HI, 8'hFF); // high alone holds compare two off
    cmp8({6'h0, compare_output_one_oe, compare_output_one}, 8'h02);
    repeat (4) u_pins.flip(1'b0, 1'b0, 1'b1);
    chk8(IDX_FLAGS, 8'h48, 8'h40);
    cmp8({6'h0, compare_output_one, timer_irq}, 8'h03);
    repeat (2) u_pins.flip(1'b0, 1'b0, 1'b1);
    chk8(IDX_FLAGS, 8'h08, 8'h00);
    repeat (2) u_pins.flip(1'b0, 1'b0, 1'b1);
    chk8(IDX_FLAGS, 8'h20, 8'h20);
    chk8(IDX_ACNT_LO, 8'hFF, 8'h00);
    chk8(IDX_FLAGS, 8'h20, 8'h20);
    chk8(IDX_CNT_LO, 8'hFF, 8'h00);
    chk8(IDX_FLAGS, 8'h20, 8'h00);
    chk8(IDX_CMP1_LO, 8'hFF, 8'hFE);
    chk8(IDX_FLAGS, 8'h40, 8'h00);
    cmp8({7'h0, timer_irq}, 8'h00);
    // forced levels, then disable drops both pin enables
    wr(IDX_CTRL_A, 8'h14);
    repeat (2) @(posedge hclk);
    cmp8({7'h0, compare_output_two}, 8'h01);
    wr(IDX_CTRL_A, 8'h08);
    repeat (2) @(posedge hclk);
    cmp8({7'h0, compare_output_one}, 8'h00);
    wr(IDX_FLAGS, 8'h04);
    repeat (2) @(posedge hclk);
    cmp8({6'h0, compare_output_one_oe,
          compare_output_two_oe}, 8'h00);
    // one-pulse: rising edge on capture one starts it at level two
    wr(IDX_CTRL_A, 8'h06);
    wr(IDX_CTRL_B, 8'hAD);
    wr(IDX_FLAGS, 8'h00);
    u_pins.flip(1'b1, 1'b0, 1'b0);
    cmp8({6'h0, compare_output_one_oe, compare_output_one}, 8'h03);
    repeat (4) u_pins.flip(1'b0, 1'b0, 1'b1);
    cmp8({7'h0, compare_output_one}, 8'h00);
    // pwm with value one FFFE and value two FFFF, stepped from FFFC
    wr(IDX_CMP2_LO, 8'hFF);
    wr(IDX_CTRL_A, 8'h01);
    wr(IDX_CTRL_B, 8'h9D);
    wr(IDX_CNT_LO, 8'h00);
    repeat (4) u_pins.flip(1'b0, 1'b0, 1'b1);
    cmp8({7'h0, compare_output_one}, 8'h01);
    repeat (2) u_pins.flip(1'b0, 1'b0, 1'b1);
    cmp8({7'h0, compare_output_one}, 8'h00);
    chk8(IDX_CNT_LO, 8'hFF, CNT_RST[7:0]);
    report_and_stop();
  end
endmodule // tb_sbtm_timer
